// File: src/fdcr_pkg.sv
package fdcr_pkg;
   // Register indices
   localparam logic [7:0] FDCR_ADDR_VMON = 8'h02;
   localparam logic [7:0] FDCR_ADDR_L1FL = 8'h03;
   localparam logic [7:0] FDCR_ADDR_L2FL = 8'h04;
   localparam logic [7:0] FDCR_ADDR_L1TO = 8'h05;
   localparam logic [7:0] FDCR_ADDR_L2TO = 8'h06;
   localparam logic [7:0] FDCR_ADDR_BOOST = 8'h07;
   // Reset values
   localparam logic [7:0] FDCR_RST_VMON = 8'h01;
   localparam logic [7:0] FDCR_RST_L1 = 8'hBF;
   localparam logic [7:0] FDCR_RST_L2 = 8'h3F;
   localparam logic [7:0] FDCR_RST_BOOST = 8'h09;
   // Writable bit masks
   localparam logic [7:0] FDCR_MASK_VMON = 8'h7F;
   localparam logic [7:0] FDCR_MASK_L1 = 8'hFF;
   localparam logic [7:0] FDCR_MASK_L2 = 8'h7F;
   localparam logic [7:0] FDCR_MASK_BOOST = 8'h8F;
   // Field positions
   localparam int FDCR_POS_UNDERVOLTAGE_LOCKOUT = 6;
   localparam int FDCR_POS_LEVEL = 3;
   localparam int FDCR_POS_HYST = 2;
   localparam int FDCR_POS_FOLLOW = 7;
   localparam int FDCR_POS_SWRST = 7;
   localparam int FDCR_POS_SHORT = 3;
   localparam int FDCR_POS_PASS = 2;
   localparam int FDCR_POS_FREQ = 1;
   localparam int FDCR_POS_ILIM = 0;
   // Analog scale (units: microamps / millivolts)
   localparam int FDCR_FLASH_STEP_NA = 11725;
   localparam int FDCR_FLASH_OFS_NA = 10900;
   localparam int FDCR_TORCH_STEP_NA = 1400;
   localparam int FDCR_TORCH_OFS_NA = 977;
   localparam int FDCR_TORCH_HI_STEP_NA = 2800;
   localparam int FDCR_TORCH_HI_OFS_NA = 1954;
   localparam int FDCR_VMON_BASE_MV = 2900;
   localparam int FDCR_VMON_STEP_MV = 100;
   localparam int FDCR_HYST_MV = 50;

   typedef enum logic [1:0] {
      FDCR_VM_OFF = 2'b00,
      FDCR_VM_HOLD = 2'b01,
      FDCR_VM_DOWN = 2'b10,
      FDCR_VM_UPDOWN = 2'b11
   } fdcr_vm_mode_t;

   typedef struct packed {
      logic [7:0] vmon;
      logic [7:0] l1fl;
      logic [7:0] l2fl;
      logic [7:0] l1to;
      logic [7:0] l2to;
      logic [7:0] boost;
   } fdcr_regs_t;

   typedef struct packed {
      logic [11:0] vmon_thresh_mv;
      logic [5:0] vmon_hyst_mv;
      fdcr_vm_mode_t vmon_mode;
      logic undervoltage_lockout_en;
      logic short_det_en;
      logic pass_only;
      logic freq_4mhz;
      logic ilim_high;
      logic soft_reset;
   } fdcr_cfg_t;
endpackage

// File: src/fdcr_level_map.sv
`timescale 1ns/1ps
`default_nettype none
module fdcr_level_map
   import fdcr_pkg::*;
(
   // Codes
   input wire logic [6:0] code,
   input wire logic hi_variant,
   // Currents in microamps
   output logic [20:0] flash_ua,
   output logic [20:0] torch_ua
);
   logic [31:0] f_na;
   logic [31:0] t_na;
   always_comb begin
      f_na = 32'(code) * 32'(FDCR_FLASH_STEP_NA) + 32'(FDCR_FLASH_OFS_NA);
      if (hi_variant) begin
         t_na = 32'(code) * 32'(FDCR_TORCH_HI_STEP_NA) + 32'(FDCR_TORCH_HI_OFS_NA);
      end else begin
         t_na = 32'(code) * 32'(FDCR_TORCH_STEP_NA) + 32'(FDCR_TORCH_OFS_NA);
      end
      // Scale constants are already in microamps
      flash_ua = 21'(f_na);
      torch_ua = 21'(t_na);
   end
endmodule
`default_nettype wire

// File: src/fdcr_vmon_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fdcr_vmon_decode
   import fdcr_pkg::*;
(
   // Raw register
   input wire logic [7:0] vmon,
   // Decoded fields
   output logic [11:0] thresh_mv,
   output logic [5:0] hyst_mv,
   output logic undervoltage_lockout_en
);
   always_comb begin
      thresh_mv = 12'(FDCR_VMON_BASE_MV) +
                  12'(vmon[FDCR_POS_LEVEL +: 3]) * 12'(FDCR_VMON_STEP_MV);
      hyst_mv = vmon[FDCR_POS_HYST] ? 6'(FDCR_HYST_MV) : 6'h00;
      undervoltage_lockout_en = vmon[FDCR_POS_UNDERVOLTAGE_LOCKOUT];
   end
endmodule
`default_nettype wire

// File: src/fdcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The 3-bit monitor level field selects 2.9 V at 000 up to 3.6 V at 111 in 0.1 V steps.
// - The hysteresis bit adds 50 mV of hysteresis when set and none when clear.
// - The 2-bit response field means off, stop-and-hold, reduce-only, reduce-and-restore.
// - Bit 6 of the monitor register enables undervoltage lockout; clear by default.
// - The response mode is frozen while driving except on reset; a new mode written while driving is taken on return to standby.
// - LED1 flash bit 7 set makes LED2 flash at the LED1 flash code.
// - Flash current is roughly code times 11.725 mA plus 10.9 mA.
// - LED1 torch bit 7 set makes LED2 torch at the LED1 torch code.
// - Writing 1 to boost bit 7 fires a software reset; the bit reads back 0.
// - Boost bit 3 enables LED short detection.
// - Boost bit 2 restricts the converter to pass mode.
// - Boost bit 1 selects 4 MHz switching instead of 2 MHz.
// - Boost bit 0 selects a 2.8 A current limit instead of 1.9 A.
// - Reset loads 0x01, 0xBF, 0x3F, 0xBF, 0x3F and 0x09 into the registers.
module fdcr_config_regs
   import fdcr_pkg::*;
#(
   parameter bit HI_TORCH_VARIANT = 1'b0
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register write port from the serial slave
   input wire logic wr_stb,
   input wire logic [7:0] wr_idx,
   input wire logic [7:0] wr_data,
   // Register read port
   input wire logic [7:0] rd_idx,
   output logic [7:0] rd_data,
   // Device state
   input wire logic drive_active,
   // Monitor configuration
   output logic [11:0] vmon_thresh_mv,
   output logic [5:0] vmon_hyst_mv,
   output fdcr_vm_mode_t vmon_mode,
   output logic undervoltage_lockout_en,
   // LED drive codes and currents
   output logic [6:0] led1_flash_code,
   output logic [6:0] led2_flash_code,
   output logic [6:0] led1_torch_code,
   output logic [6:0] led2_torch_code,
   output logic [20:0] led1_flash_ua,
   output logic [20:0] led2_flash_ua,
   output logic [20:0] led1_torch_ua,
   output logic [20:0] led2_torch_ua,
   // Boost configuration
   output logic short_det_en,
   output logic pass_only,
   output logic freq_4mhz,
   output logic ilim_high,
   output logic soft_reset
);
   typedef struct packed {
      fdcr_regs_t regs;
      fdcr_vm_mode_t mode;
      logic swrst;
      logic [7:0] rdat;
      logic [6:0] c_l1f;
      logic [6:0] c_l2f;
      logic [6:0] c_l1t;
      logic [6:0] c_l2t;
      logic [20:0] u_l1f;
      logic [20:0] u_l2f;
      logic [20:0] u_l1t;
      logic [20:0] u_l2t;
      logic [11:0] thr;
      logic [5:0] hys;
      logic undervoltage_lockout;
   } fdcr_state_t;

   localparam fdcr_state_t FDCR_ST_RST = '{
      regs: '{vmon: FDCR_RST_VMON, l1fl: FDCR_RST_L1, l2fl: FDCR_RST_L2,
              l1to: FDCR_RST_L1, l2to: FDCR_RST_L2, boost: FDCR_RST_BOOST},
      mode: fdcr_vm_mode_t'(FDCR_RST_VMON[1:0]),
      swrst: 1'b0,
      rdat: 8'h00,
      c_l1f: FDCR_RST_L1[6:0],
      c_l2f: FDCR_RST_L1[6:0],
      c_l1t: FDCR_RST_L1[6:0],
      c_l2t: FDCR_RST_L1[6:0],
      u_l1f: 21'h00_0000,
      u_l2f: 21'h00_0000,
      u_l1t: 21'h00_0000,
      u_l2t: 21'h00_0000,
      thr: 12'(FDCR_VMON_BASE_MV),
      hys: 6'h00,
      undervoltage_lockout: 1'b0
   };

   fdcr_state_t st_ff;
   fdcr_state_t nxt_st;
   logic [20:0] m_fl [4];
   logic [20:0] m_to [4];
   logic [6:0] code_sel [4];
   logic [11:0] dec_thr;
   logic [5:0] dec_hys;
   logic dec_undervoltage_lockout;

   // One mapper per LED code slot
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_map
         fdcr_level_map u_map (
            .code(code_sel[gi]),
            .hi_variant(HI_TORCH_VARIANT),
            .flash_ua(m_fl[gi]),
            .torch_ua(m_to[gi])
         );
      end
   endgenerate

   fdcr_vmon_decode u_vdec (
      .vmon(st_ff.regs.vmon),
      .thresh_mv(dec_thr),
      .hyst_mv(dec_hys),
      .undervoltage_lockout_en(dec_undervoltage_lockout)
   );

   always_comb begin
      code_sel[0] = st_ff.c_l1f;
      code_sel[1] = st_ff.c_l2f;
      code_sel[2] = st_ff.c_l1t;
      code_sel[3] = st_ff.c_l2t;
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.swrst = 1'b0;
      if (wr_stb) begin
         case (wr_idx)
            FDCR_ADDR_VMON: begin
               nxt_st.regs.vmon = wr_data & FDCR_MASK_VMON;
            end
            FDCR_ADDR_L1FL: begin
               nxt_st.regs.l1fl = wr_data & FDCR_MASK_L1;
            end
            FDCR_ADDR_L2FL: begin
               nxt_st.regs.l2fl = wr_data & FDCR_MASK_L2;
            end
            FDCR_ADDR_L1TO: begin
               nxt_st.regs.l1to = wr_data & FDCR_MASK_L1;
            end
            FDCR_ADDR_L2TO: begin
               nxt_st.regs.l2to = wr_data & FDCR_MASK_L2;
            end
            FDCR_ADDR_BOOST: begin
               // Reset bit is a strobe, not stored
               nxt_st.regs.boost = wr_data & FDCR_MASK_BOOST & ~8'h80;
               nxt_st.swrst = wr_data[FDCR_POS_SWRST];
            end
            default: begin
            end
         endcase
      end
      // Mode only follows the register while in standby
      if (!drive_active) begin
         nxt_st.mode = fdcr_vm_mode_t'(st_ff.regs.vmon[1:0]);
      end
      nxt_st.c_l1f = st_ff.regs.l1fl[6:0];
      nxt_st.c_l2f = st_ff.regs.l1fl[FDCR_POS_FOLLOW] ?
                     st_ff.regs.l1fl[6:0] : st_ff.regs.l2fl[6:0];
      nxt_st.c_l1t = st_ff.regs.l1to[6:0];
      nxt_st.c_l2t = st_ff.regs.l1to[FDCR_POS_FOLLOW] ?
                     st_ff.regs.l1to[6:0] : st_ff.regs.l2to[6:0];
      nxt_st.u_l1f = m_fl[0];
      nxt_st.u_l2f = m_fl[1];
      nxt_st.u_l1t = m_to[2];
      nxt_st.u_l2t = m_to[3];
      nxt_st.thr = dec_thr;
      nxt_st.hys = dec_hys;
      nxt_st.undervoltage_lockout = dec_undervoltage_lockout;
      case (rd_idx)
         FDCR_ADDR_VMON: nxt_st.rdat = st_ff.regs.vmon;
         FDCR_ADDR_L1FL: nxt_st.rdat = st_ff.regs.l1fl;
         FDCR_ADDR_L2FL: nxt_st.rdat = st_ff.regs.l2fl;
         FDCR_ADDR_L1TO: nxt_st.rdat = st_ff.regs.l1to;
         FDCR_ADDR_L2TO: nxt_st.rdat = st_ff.regs.l2to;
         FDCR_ADDR_BOOST: nxt_st.rdat = st_ff.regs.boost;
         default: nxt_st.rdat = 8'h00;
      endcase
      // Software reset restores defaults but keeps the pulse visible
      if (st_ff.swrst) begin
         nxt_st = FDCR_ST_RST;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= FDCR_ST_RST;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      rd_data = st_ff.rdat;
      vmon_thresh_mv = st_ff.thr;
      vmon_hyst_mv = st_ff.hys;
      vmon_mode = st_ff.mode;
      undervoltage_lockout_en = st_ff.undervoltage_lockout;
      led1_flash_code = st_ff.c_l1f;
      led2_flash_code = st_ff.c_l2f;
      led1_torch_code = st_ff.c_l1t;
      led2_torch_code = st_ff.c_l2t;
      led1_flash_ua = st_ff.u_l1f;
      led2_flash_ua = st_ff.u_l2f;
      led1_torch_ua = st_ff.u_l1t;
      led2_torch_ua = st_ff.u_l2t;
      short_det_en = st_ff.regs.boost[FDCR_POS_SHORT];
      pass_only = st_ff.regs.boost[FDCR_POS_PASS];
      freq_4mhz = st_ff.regs.boost[FDCR_POS_FREQ];
      ilim_high = st_ff.regs.boost[FDCR_POS_ILIM];
      soft_reset = st_ff.swrst;
   end
endmodule
`default_nettype wire

// File: sim/fdcr_config_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fdcr_config_regs_asserts
   import fdcr_pkg::*;
#(
   parameter bit HI_TORCH_VARIANT = 1'b0
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register ports
   input wire logic wr_stb,
   input wire logic [7:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_idx,
   input wire logic [7:0] rd_data,
   input wire logic drive_active,
   // Decoded outputs
   input wire logic [11:0] vmon_thresh_mv,
   input wire logic [5:0] vmon_hyst_mv,
   input wire logic [1:0] vmon_mode,
   input wire logic undervoltage_lockout_en,
   input wire logic [6:0] led2_flash_code,
   input wire logic [6:0] led2_torch_code,
   input wire logic [20:0] led1_flash_ua,
   input wire logic [20:0] led1_torch_ua,
   input wire logic short_det_en,
   input wire logic pass_only,
   input wire logic freq_4mhz,
   input wire logic ilim_high,
   input wire logic soft_reset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire wr_ok = clk_en && wr_stb;

   AST_VMON_FIELDS: assert property (wr_ok && wr_idx == 8'h02 |-> ##2
      vmon_thresh_mv == 12'(2900 + 100 * $past(wr_data[5:3], 2)) && undervoltage_lockout_en == $past(wr_data[6], 2)
      && vmon_hyst_mv == ($past(wr_data[2], 2) ? 6'd50 : 6'd0)) else $error("monitor fields wrong");
   AST_VMON_MODE: assert property ((wr_ok && wr_idx == 8'h02 && !drive_active) ##1 (!drive_active)[*2]
      |-> vmon_mode == fdcr_vm_mode_t'($past(wr_data[1:0], 2))) else $error("mode not taken");
   AST_MODE_FROZEN: assert property (drive_active[*3] |-> $stable(vmon_mode))
      else $error("mode moved while driving");
   AST_FLASH_FOLLOW: assert property (wr_ok && wr_idx == 8'h03 && wr_data[7] |-> ##2
      led2_flash_code == $past(wr_data[6:0], 2)) else $error("led2 flash not following");
   AST_FLASH_UA: assert property (wr_ok && wr_idx == 8'h03 |-> ##3
      led1_flash_ua == 21'($past(wr_data[6:0], 3) * 11725 + 10900)) else $error("flash current");
   AST_TORCH_FOLLOW: assert property (wr_ok && wr_idx == 8'h05 && wr_data[7] |-> ##2
      led2_torch_code == $past(wr_data[6:0], 2)) else $error("led2 torch not following");
   AST_TORCH_UA: assert property (wr_ok && wr_idx == 8'h05 |-> ##3 led1_torch_ua ==
      21'($past(wr_data[6:0], 3) * (HI_TORCH_VARIANT ? 2800 : 1400) + (HI_TORCH_VARIANT ? 1954 : 977)))
      else $error("torch current");
   AST_SWRST: assert property (wr_ok && wr_idx == 8'h07 && wr_data[7] |=> soft_reset ##1
      (!soft_reset && short_det_en && ilim_high && !pass_only && !freq_4mhz))
      else $error("soft reset sequence");
   AST_BOOST_BITS: assert property (wr_ok && wr_idx == 8'h07 && !wr_data[7] |=>
      {short_det_en, pass_only, freq_4mhz, ilim_high} == $past(wr_data[3:0]) && !soft_reset)
      else $error("boost bits wrong");
   AST_RSVD_READ: assert property (clk_en && rd_idx inside {8'h02, 8'h04, 8'h06, 8'h07} |=>
      !rd_data[7]) else $error("reserved bit read as one");
   AST_UNMAPPED_READ: assert property (clk_en && !(rd_idx inside {[8'h02:8'h07]}) |=>
      rd_data == 8'h00) else $error("unmapped read not zero");
   AST_RST_VALUES: assert property ($fell(sys_rst) |-> vmon_thresh_mv == 12'd2900 &&
      vmon_mode == FDCR_VM_HOLD && led2_flash_code == 7'h3F && short_det_en && ilim_high)
      else $error("reset values wrong");

   COV_SWRST: cover property (soft_reset);
   COV_FROZEN: cover property (drive_active && wr_ok && wr_idx == 8'h02);
   COV_NOFOLLOW: cover property (wr_ok && wr_idx == 8'h03 && !wr_data[7]);
endmodule
`default_nettype wire

// File: sim/fdcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdcr_host_model (
   // Clock
   input wire logic ref_clk,
   // Write port toward the registers
   output logic wr_stb,
   output logic [7:0] wr_idx,
   output logic [7:0] wr_data
);
   initial begin
      wr_stb = 1'b0;
      wr_idx = 8'h00;
      wr_data = 8'h00;
   end
   // Index and data byte arrive together under one strobe
   task automatic write_reg(input logic [7:0] idx, input logic [7:0] data, input int gap);
      @(posedge ref_clk);
      wr_stb <= 1'b1;
      wr_idx <= idx;
      wr_data <= data;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      // Released bus must not look like the last transfer
      wr_idx <= ~idx;
      wr_data <= ~data;
      repeat (gap) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic drive_active = 1'b0;
   logic [7:0] rd_idx = 8'h00;
   logic wr_stb, undervoltage_lockout_en, short_det_en, pass_only, freq_4mhz, ilim_high, soft_reset;
   logic [7:0] wr_idx, wr_data, rd_data;
   logic [11:0] vmon_thresh_mv;
   logic [5:0] vmon_hyst_mv;
   fdcr_pkg::fdcr_vm_mode_t vmon_mode;
   logic [6:0] led1_flash_code, led2_flash_code, led1_torch_code, led2_torch_code;
   logic [20:0] led1_flash_ua, led2_flash_ua, led1_torch_ua, led2_torch_ua;
   logic [7:0] rst_tab [6] = '{8'h01, 8'hBF, 8'h3F, 8'hBF, 8'h3F, 8'h09};
   logic [7:0] msk_tab [5] = '{8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'h7F};
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;

   always #12.5 ref_clk = ~ref_clk;

   fdcr_host_model u_fdcr_host_model (.ref_clk, .wr_stb, .wr_idx, .wr_data);
   fdcr_config_regs u_fdcr_config_regs (
      .ref_clk, .sys_rst, .clk_en, .wr_stb, .wr_idx, .wr_data, .rd_idx, .rd_data,
      .drive_active, .vmon_thresh_mv, .vmon_hyst_mv, .vmon_mode, .undervoltage_lockout_en,
      .led1_flash_code, .led2_flash_code, .led1_torch_code, .led2_torch_code,
      .led1_flash_ua, .led2_flash_ua, .led1_torch_ua, .led2_torch_ua,
      .short_det_en, .pass_only, .freq_4mhz, .ilim_high, .soft_reset
   );

   task automatic test_done();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      u_fdcr_host_model.write_reg(idx, data, 0);
   endtask
   task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge ref_clk);
      rd_idx <= idx;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("read data", 21'(rd_data), 21'(exp));
   endtask
   // Longest output path is three cycles behind the write
   task automatic settle();
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) chk_rd(8'(i + 2), rst_tab[i]);
      chk_rd(8'h08, 8'h00);
      wr(8'h08, 8'hFF);
      chk_rd(8'h08, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(8'(i + 2), 8'hFF);
         chk_rd(8'(i + 2), msk_tab[i]);
      end
      for (int b = 0; b < 2; b++) begin
         wr(8'h07, b ? 8'h00 : 8'h0F);
         chk_rd(8'h07, b ? 8'h00 : 8'h0F);
         check("boost", 21'({short_det_en, pass_only, freq_4mhz, ilim_high}), b ? 21'h0 : 21'hF);
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h02, {1'b0, c[0], c[2:0], c[1], c[1:0]});
         settle();
         check("level", 21'(vmon_thresh_mv), 21'(2900 + 100 * c));
         check("hyst", 21'(vmon_hyst_mv), c[1] ? 21'd50 : 21'd0);
         check("mode", 21'(vmon_mode), 21'(c[1:0]));
         check("lockout", 21'(undervoltage_lockout_en), 21'(c[0]));
      end
      @(posedge ref_clk);
      drive_active <= 1'b1;
      wr(8'h02, 8'h02);
      settle();
      check("mode", 21'(vmon_mode), 21'h3);
      @(posedge ref_clk);
      drive_active <= 1'b0;
      settle();
      check("mode", 21'(vmon_mode), 21'h2);
      for (int k = 0; k < 2; k++) begin
         wr(8'h03, k ? 8'h7F : 8'h85);
         wr(8'h04, 8'h22);
         wr(8'h05, k ? 8'h00 : 8'h85);
         wr(8'h06, 8'h22);
         settle();
         check("flash2", 21'(led2_flash_code), k ? 21'h22 : 21'h5);
         check("torch2", 21'(led2_torch_code), k ? 21'h22 : 21'h5);
         check("flash1", 21'(led1_flash_code), k ? 21'h7F : 21'h5);
         check("torch1", 21'(led1_torch_code), k ? 21'h0 : 21'h5);
         check("flash_ua", led1_flash_ua, 21'((k ? 127 : 5) * 11725 + 10900));
         check("flash2_ua", led2_flash_ua, 21'((k ? 34 : 5) * 11725 + 10900));
         check("torch2_ua", led2_torch_ua, 21'((k ? 34 : 5) * 1400 + 977));
         check("torch_ua", led1_torch_ua, k ? 21'd977 : 21'(5 * 1400 + 977));
      end
      wr(8'h07, 8'h8B);
      @(negedge ref_clk);
      check("soft_reset", 21'(soft_reset), 21'h1);
      chk_rd(8'h07, 8'h09);
      chk_rd(8'h03, 8'hBF);
      check("soft_reset", 21'(soft_reset), 21'h0);
      check("boost", 21'({short_det_en, pass_only, freq_4mhz, ilim_high}), 21'h9);
      // Write lands while reset is still high, so it must be lost
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      wr(8'h02, 8'h38);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      chk_rd(8'h02, 8'h01);
      check("level", 21'(vmon_thresh_mv), 21'd2900);
      test_done();
   end
endmodule

bind fdcr_config_regs fdcr_config_regs_asserts #(.HI_TORCH_VARIANT(HI_TORCH_VARIANT))
   u_fdcr_config_regs_asserts (
   .ref_clk, .sys_rst, .clk_en, .wr_stb, .wr_idx, .wr_data, .rd_idx, .rd_data, .drive_active,
   .vmon_thresh_mv, .vmon_hyst_mv, .vmon_mode, .undervoltage_lockout_en, .led2_flash_code, .led2_torch_code,
   .led1_flash_ua, .led1_torch_ua, .short_det_en, .pass_only, .freq_4mhz, .ilim_high, .soft_reset
);
`default_nettype wire
